// file: rtl/port_pin_levels_defs.svh
// register offsets, field positions and reset values for the port A block
`ifndef PORT_PIN_LEVELS_DEFS_SVH
`define PORT_PIN_LEVELS_DEFS_SVH

// register byte addresses
`define OFS_PIN_LEVELS      12'h000
`define OFS_OUTPUT_LATCH    12'h004
`define OFS_DIRECTION       12'h008
`define OFS_CONV_CTRL       12'h00C
`define OFS_PIN_CONFIG      12'h010
// converter_control_one field
`define CONV_CFG_LSB        0
`define CONV_CFG_W          4
`define CONV_CTRL_RST       8'h00
// pin_config fields: comparator enables, reference out, clock mode
`define CFG_CMP1_EN_BIT     0
`define CFG_CMP2_EN_BIT     1
`define CFG_VREF_OE_BIT     2
`define CFG_MODE_LSB        4
`define CFG_MODE_W          3
// reset values
`define DIR_RST             8'hFF
`define LATCH_RST           8'h00
`define PORT_BITS           7
`define BIT_SIX             6
// converter config threshold: cfg >= value makes a pin digital
`define CFG_DIG_AN0         4'hE
`define CFG_DIG_AN1         4'hD
`define CFG_DIG_AN2         4'hC
`define CFG_DIG_AN3         4'hB
`define CFG_DIG_AN4         4'hA
// cycle clock divide by four
`define CYC_DIV             2'h3

`endif

// file: rtl/port_pin_levels_pkg.sv
// types shared by the port A block
package port_pin_levels_pkg;
   // oscillator / clock mode of the pin six function
   typedef enum logic [2:0]
   {
      mode_ext_clock_io       = 3'b000,
      mode_ext_clock_pll_io   = 3'b001,
      mode_int_osc_io         = 3'b010,
      mode_ext_clock          = 3'b011,
      mode_ext_clock_pll      = 3'b100,
      mode_int_osc_clockout   = 3'b101,
      mode_crystal            = 3'b110,
      mode_crystal_pll        = 3'b111
   } osc_mode_t;
endpackage : port_pin_levels_pkg

// file: rtl/pin_sync.sv
// two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 7
) (
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // async in, synced out
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_r; // first stage, read only by second stage

   // two stages; nothing else reads meta_r
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_r   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule : pin_sync
`default_nettype wire

// file: rtl/cycle_clock_div.sv
// divide-by-four cycle clock generator, also a one-cycle enable
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_levels_defs.svh"
module cycle_clock_div (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // outputs
   output logic      cycle_clk,
   output logic      cycle_en
);
   logic [1:0] cnt_r; // phase counter

   // free running phase count
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_r <= 2'h0;
      else
         cnt_r <= cnt_r + 2'h1;
   end

   // square wave at a quarter of pclk, registered to stay glitch free
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cycle_clk <= 1'b0;
         cycle_en  <= 1'b0;
      end
      else
      begin
         cycle_clk <= (cnt_r < 2'h2);
         cycle_en  <= (cnt_r == `CYC_DIV);
      end
   end
endmodule : cycle_clock_div
`default_nettype wire

// file: rtl/port_a_gpio.sv
// port A general purpose I/O with pin sharing, APB register slave
// Functional notes
// - direction one: driver off, pin is input
// - direction zero: pin driven from latch
// - port read gives pins, write sets latch
// - latch separately mapped, reads latch value
// - pin six I/O only in I/O modes
// - reset: analog pins read zero, pin four digital
// - converter config field selects analog pins
// - analog kills digital input, not output
// - comparator outputs override latch on four, five
// - reference output disables pin two I/O
// - clock modes put cycle clock on six
// - bit seven: zero in port/latch, one direction
// - pin four always feeds usb receive
// - pin four feeds timer zero clock
// - enabled reference takes pin two from I/O; comparators replace latch only when direction zero
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_levels_defs.svh"
module port_a_gpio #(
   parameter int N = `PORT_BITS
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // pins: input, output, output enable (low = drive)
   input  wire logic [N-1:0] pin_in,
   output logic      [N-1:0] pin_out,
   output logic      [N-1:0] pin_oe_n,
   // peripheral sharing
   input  wire logic        comparator_one_out,
   input  wire logic        comparator_two_out,
   output logic             usb_xcvr_receive_in,
   output logic             timer_zero_clock_in,
   output logic [5:0]       analog_sel
);
   // register state
   logic [N-1:0] latch_r;      // output latch
   logic [N-1:0] dir_r;        // direction, one = input
   logic [7:0]   conv_ctrl_r;  // converter_control_one
   logic [7:0]   cfg_r;        // comparator / reference / mode config
   logic [N-1:0] pin_sync_w;   // synchronised pin levels
   logic         cyc_clk;      // quarter-rate clock
   logic         cyc_en;       // unused enable output of divider

   // decoded controls
   logic [3:0]   conv_cfg;
   port_pin_levels_pkg::osc_mode_t mode;
   logic         six_io;       // pin six usable as I/O
   logic         six_cycle_clock_out;     // pin six carries cycle clock
   logic         vref_oe;
   logic         cmp1_en;
   logic         cmp2_en;
   logic [N-1:0] analog_w;     // per-pin analog selection
   logic [N-1:0] dig_in_w;     // digital input levels after gating

   // apb strobes
   logic         wr_en;
   logic         rd_en;
   logic         addr_ok;

   assign conv_cfg = conv_ctrl_r[`CONV_CFG_LSB +: `CONV_CFG_W];
   assign mode     = port_pin_levels_pkg::osc_mode_t'(cfg_r[`CFG_MODE_LSB +: `CFG_MODE_W]);
   assign vref_oe  = cfg_r[`CFG_VREF_OE_BIT];
   assign cmp1_en  = cfg_r[`CFG_CMP1_EN_BIT];
   assign cmp2_en  = cfg_r[`CFG_CMP2_EN_BIT];

   // pin six ownership from oscillator mode
   always_comb
   begin
      six_io   = 1'b0;
      six_cycle_clock_out = 1'b0;
      case (mode)
         port_pin_levels_pkg::mode_ext_clock_io,
         port_pin_levels_pkg::mode_ext_clock_pll_io,
         port_pin_levels_pkg::mode_int_osc_io:
            six_io = 1'b1;
         port_pin_levels_pkg::mode_ext_clock,
         port_pin_levels_pkg::mode_ext_clock_pll,
         port_pin_levels_pkg::mode_int_osc_clockout:
            six_cycle_clock_out = 1'b1;
         default:
            six_io = 1'b0; // crystal feedback owns the pin
      endcase
   end

   // converter config thresholds; reset value 0 makes pins 0-3 and 5 analog
   always_comb
   begin
      analog_w    = '0;
      analog_w[0] = (conv_cfg < `CFG_DIG_AN0);
      analog_w[1] = (conv_cfg < `CFG_DIG_AN1);
      analog_w[2] = (conv_cfg < `CFG_DIG_AN2);
      analog_w[3] = (conv_cfg < `CFG_DIG_AN3);
      analog_w[5] = (conv_cfg < `CFG_DIG_AN4);
   end
   assign analog_sel = {analog_w[5], 1'b0, analog_w[3:0]};

   // pin level synchroniser ahead of read path
   pin_sync #(
      .W (N)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (pin_in),
      .sync_out (pin_sync_w)
   );

   // cycle clock source for pin six
   cycle_clock_div u_div (
      .pclk      (pclk),
      .presetn   (presetn),
      .cycle_clk (cyc_clk),
      .cycle_en  (cyc_en)
   );

   // digital input gating: analog, reference and pin six ownership
   always_comb
   begin
      dig_in_w = pin_sync_w & ~analog_w;
      if (vref_oe)
         dig_in_w[2] = 1'b0;
      if (!six_io)
         dig_in_w[`BIT_SIX] = 1'b0;
   end

   // peripheral inputs from pin four; direction does not matter
   assign usb_xcvr_receive_in = pin_sync_w[4];
   assign timer_zero_clock_in = pin_sync_w[4];

   // pin drivers: latch by default, peripherals override
   always_comb
   begin
      pin_out  = latch_r;
      pin_oe_n = dir_r;
      if (cmp1_en && !dir_r[4])
         pin_out[4] = comparator_one_out;
      if (cmp2_en && !dir_r[5])
         pin_out[5] = comparator_two_out;
      if (vref_oe)
      begin
         pin_out[2]  = 1'b0;
         pin_oe_n[2] = 1'b1;
      end
      if (six_cycle_clock_out)
      begin
         pin_out[`BIT_SIX]  = cyc_clk;
         pin_oe_n[`BIT_SIX] = 1'b0;
      end
      else if (!six_io)
      begin
         pin_out[`BIT_SIX]  = 1'b0; // oscillator owns the pin
         pin_oe_n[`BIT_SIX] = 1'b1;
      end
   end

   // apb decode; zero wait states
   assign addr_ok = (paddr == `OFS_PIN_LEVELS) || (paddr == `OFS_OUTPUT_LATCH) ||
                    (paddr == `OFS_DIRECTION) || (paddr == `OFS_CONV_CTRL) ||
                    (paddr == `OFS_PIN_CONFIG);
   assign wr_en   = psel && penable && pwrite && addr_ok && pstrb[0];
   assign rd_en   = psel && !pwrite;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   // output latch: port and latch offsets both write it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         latch_r <= N'(`LATCH_RST);
      else if (wr_en && ((paddr == `OFS_PIN_LEVELS) || (paddr == `OFS_OUTPUT_LATCH)))
         latch_r <= pwdata[N-1:0];
   end

   // direction register; analog pins rely on software keeping it set
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         dir_r <= N'(`DIR_RST);
      else if (wr_en && (paddr == `OFS_DIRECTION))
         dir_r <= pwdata[N-1:0];
   end

   // converter and config registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         conv_ctrl_r <= `CONV_CTRL_RST;
         cfg_r       <= 8'h00;
      end
      else if (wr_en && (paddr == `OFS_CONV_CTRL))
         conv_ctrl_r <= pwdata[7:0];
      else if (wr_en && (paddr == `OFS_PIN_CONFIG))
         cfg_r <= pwdata[7:0];
   end

   // read data, registered at the setup cycle so it is valid in access
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_en && !penable)
      begin
         prdata <= 32'h0000_0000;
         if (paddr == `OFS_PIN_LEVELS)
            prdata[N-1:0] <= dig_in_w;
         else if (paddr == `OFS_OUTPUT_LATCH)
         begin
            prdata[N-1:0]      <= latch_r;
            prdata[`BIT_SIX]   <= six_io & latch_r[`BIT_SIX];
         end
         else if (paddr == `OFS_DIRECTION)
         begin
            prdata[N-1:0]    <= dir_r;
            prdata[`BIT_SIX] <= six_io & dir_r[`BIT_SIX];
            prdata[7]        <= 1'b1;
         end
         else if (paddr == `OFS_CONV_CTRL)
            prdata[7:0] <= conv_ctrl_r;
         else if (paddr == `OFS_PIN_CONFIG)
            prdata[7:0] <= cfg_r;
      end
   end
endmodule : port_a_gpio
`default_nettype wire

// file: testbench/port_a_chk.sv
// port-level assertions for the port A block
`timescale 1ns/1ps
`default_nettype none
module port_a_chk #(
   parameter int N = 7
) (
   // clock, reset, apb
   input wire logic         pclk,
   input wire logic         presetn,
   input wire logic         psel,
   input wire logic         penable,
   input wire logic         pwrite,
   input wire logic [11:0]  paddr,
   input wire logic [31:0]  prdata,
   input wire logic         pready,
   input wire logic         pslverr,
   // pins and sharing
   input wire logic [N-1:0] pin_in,
   input wire logic [N-1:0] pin_oe_n,
   input wire logic         usb_xcvr_receive_in,
   input wire logic         timer_zero_clock_in,
   input wire logic [5:0]   analog_sel
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // access phase of a transfer
   sequence acc;
      psel && penable;
   endsequence
   a_zero_wait: assert property (acc |-> pready)
      else $error("access without ready");
   a_unmapped_err: assert property (acc ##0 paddr > 12'h010 |-> pslverr)
      else $error("no error on unmapped place");
   a_mapped_ok: assert property (acc ##0 paddr <= 12'h010
      ##0 paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("error on mapped place");
   a_upper_zero: assert property (acc ##0 !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   // sync chain needs two clean edges before it is trusted
   a_usb_sync: assert property ($past(presetn) && $past(presetn, 2)
      |-> usb_xcvr_receive_in == $past(pin_in[4], 2))
      else $error("receive path not two edges behind pin");
   a_timer_same: assert property (timer_zero_clock_in == usb_xcvr_receive_in)
      else $error("timer clock differs from pin four");
   a_reset_analog: assert property ($rose(presetn) |-> analog_sel == 6'h2F)
      else $error("analog pins not selected after reset");
   a_reset_off: assert property ($rose(presetn) |-> &pin_oe_n)
      else $error("a pin driven after reset");
   a_oe_by_write: assert property (!$stable(pin_oe_n)
      |-> $past(psel && penable && pwrite))
      else $error("driver enable moved without a write");
endmodule : port_a_chk
bind port_a_gpio port_a_chk #(.N(N)) chk (.*);
`default_nettype wire

// file: testbench/pin_board.sv
// board model: resolves each pin from the block or the board
`timescale 1ns/1ps
`default_nettype none
module pin_board (
   // clock
   input  wire logic       pclk,
   // block side
   input  wire logic [6:0] pin_out,
   input  wire logic [6:0] pin_oe_n,
   // board drive, enable high
   input  wire logic [6:0] ext_val,
   input  wire logic [6:0] ext_en,
   // resolved level
   output logic      [6:0] pin_lvl
);
   logic [6:0] float_r = 7'h55; // no pull here, so a loose pin wanders
   // toggle each cycle so a stale value never passes
   always_ff @(posedge pclk)
      float_r <= ~float_r;
   // block driver wins when enabled, else board, else floating
   always_comb
      for (int i = 0; i < 7; i++)
         pin_lvl[i] = !pin_oe_n[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : float_r[i];
endmodule : pin_board
`default_nettype wire

// file: testbench/port_a_gpio_with_pin_muxing_tb_top.sv
// self-checking bench for the port A block
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_levels_defs.svh"
module port_a_gpio_with_pin_muxing_tb_top;
   // clock, reset, apb
   logic        pclk = 1'h0;
   logic        presetn = 1'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hF;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   // pins and sharing
   logic [6:0]  pin_in;
   logic [6:0]  pin_out;
   logic [6:0]  pin_oe_n;
   logic        comparator_one_out = 1'h0;
   logic        comparator_two_out = 1'h0;
   logic        usb_xcvr_receive_in;
   logic        timer_zero_clock_in;
   logic [5:0]  analog_sel;
   // board drive, last answer
   logic [6:0]  ext_val = 7'h7F;
   logic [6:0]  ext_en = 7'h7F;
   logic [31:0] rd;
   logic        err;
   int          miscompares = 0;
   int          n_tests = 0;
   always #5 pclk = ~pclk;
   port_a_gpio dut (.*);
   pin_board pins (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val),
      .ext_en(ext_en), .pin_lvl(pin_in));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer, held until ready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do
         @(posedge pclk);
      while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'h1, a, {24'h0, d});
   endtask : wr
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk(rd, exp);
   endtask : rdchk
   // a pin change needs three edges to reach a read
   task automatic pinwait();
      repeat (3) @(posedge pclk);
   endtask : pinwait
   task automatic t_reset();
      pinwait();
      rdchk(`OFS_PIN_LEVELS, 32'h50);
      rdchk(`OFS_OUTPUT_LATCH, 32'h00);
      rdchk(`OFS_DIRECTION, 32'hFF);
   endtask : t_reset
   task automatic t_io();
      wr(`OFS_CONV_CTRL, 8'h0F);
      ext_en <= 7'h00;
      wr(`OFS_OUTPUT_LATCH, 8'h2A);
      wr(`OFS_DIRECTION, 8'h00);
      #1 chk({18'h0, pin_oe_n, pin_out}, 32'h2A);
      pinwait();
      rdchk(`OFS_PIN_LEVELS, 32'h2A);
      wr(`OFS_PIN_LEVELS, 8'h13);
      rdchk(`OFS_OUTPUT_LATCH, 32'h13);
      wr(`OFS_DIRECTION, 8'h7F);
      ext_en <= 7'h7F;
      ext_val <= 7'h55;
      pinwait();
      rdchk(`OFS_PIN_LEVELS, 32'h55);
      rdchk(`OFS_OUTPUT_LATCH, 32'h13);
   endtask : t_io
   // direction stays all-input while pins are analog
   task automatic t_analog();
      ext_val <= 7'h7F;
      for (int c = 0; c < 16; c++)
      begin
         wr(`OFS_CONV_CTRL, 8'(c));
         #1 chk({26'h0, analog_sel}, {26'h0, c < 10, 1'h0, c < 11, c < 12, c < 13, c < 14});
      end
      wr(`OFS_CONV_CTRL, 8'h00);
      pinwait();
      rdchk(`OFS_PIN_LEVELS, 32'h50);
   endtask : t_analog
   task automatic t_share();
      wr(`OFS_CONV_CTRL, 8'h0F);
      ext_en <= 7'h00;
      wr(`OFS_OUTPUT_LATCH, 8'h30);
      wr(`OFS_DIRECTION, 8'h00);
      wr(`OFS_PIN_CONFIG, 8'h07);
      #1 chk({29'h0, pin_oe_n[2], pin_out[5:4]}, 32'h4);
      @(posedge pclk);
      comparator_one_out <= 1'h1;
      comparator_two_out <= 1'h1;
      #1 chk({30'h0, pin_out[5:4]}, 32'h3);
      @(posedge pclk);
      comparator_one_out <= 1'h0;
      comparator_two_out <= 1'h0;
      pinwait();
      rdchk(`OFS_PIN_LEVELS, 32'h00);
      wr(`OFS_PIN_CONFIG, 8'h04);
      #1 chk({30'h0, pin_out[5:4]}, 32'h3);
      wr(`OFS_DIRECTION, 8'h7F);
      ext_en <= 7'h7F;
      ext_val <= 7'h10;
      pinwait();
      chk({30'h0, usb_xcvr_receive_in, timer_zero_clock_in}, 32'h3);
   endtask : t_share
   task automatic t_mode();
      logic [6:0] v;
      ext_en <= 7'h3F;
      wr(`OFS_OUTPUT_LATCH, 8'h40);
      for (int m = 0; m < 8; m++)
      begin
         wr(`OFS_PIN_CONFIG, {1'h0, 3'(m), 4'h0});
         rdchk(`OFS_OUTPUT_LATCH, m < 3 ? 32'h40 : 32'h00);
         rdchk(`OFS_DIRECTION, m < 3 ? 32'hFF : 32'hBF);
         if (m inside {3, 4, 5})
         begin
            for (int k = 0; k < 6; k++)
            begin
               @(posedge pclk);
               #1 v[k] = pin_out[6];
            end
            chk({28'h0, v[3:0] ^ v[5:2]}, {28'h0, ~pin_oe_n[6], 3'h7});
         end
      end
   endtask : t_mode
   task automatic t_unmapped();
      apb(1'h1, 12'h014, 32'hFF);
      apb(1'h0, 12'h014, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
   endtask : t_unmapped
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   // watchdog well beyond the few hundred cycles needed
   initial
   begin
      #200000;
      miscompares++;
      finish_test();
   end
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      t_reset();
      t_io();
      t_analog();
      t_share();
      t_mode();
      t_unmapped();
      finish_test();
   end
endmodule : port_a_gpio_with_pin_muxing_tb_top
`default_nettype wire
